/* File: logic/wdtfg_pkg.sv */
// Package for the supervision timer with feed guard.
// Assumes an 8-bit special-function register bus on the CPU clock.
package wdtfg_pkg;
  // Register addresses on the special-function bus.
  localparam logic [7:0] ADDR_CONTROL     = 8'hA7;
  localparam logic [7:0] ADDR_RELOAD      = 8'hC1;
  localparam logic [7:0] ADDR_FEED_FIRST  = 8'hC2;
  localparam logic [7:0] ADDR_FEED_SECOND = 8'hC3;
  // Feed sequence values.
  localparam logic [7:0] FEED_FIRST_VALUE  = 8'hA5;
  localparam logic [7:0] FEED_SECOND_VALUE = 8'h5A;
  // Control register field positions.
  localparam int BIT_CLKSEL = 0;
  localparam int BIT_TOF    = 1;
  localparam int BIT_RUN    = 2;
  localparam int BIT_PRE_LO = 5;
  // Reset values of control fields and reload.
  localparam logic [2:0] RESET_PRE    = 3'h7;
  localparam logic       RESET_RUN    = 1'b1;
  localparam logic       RESET_CLKSEL = 1'b1;
  localparam logic [7:0] RESET_RELOAD = 8'hFF;
  // Structure of the timer.
  localparam int PRESCALER_BITS = 13;
  localparam int COUNTER_BITS   = 8;
  localparam int TAP_BASE       = 5;
  // Clock-source switch synchroniser length in cycles of each clock.
  localparam int SWITCH_STAGES  = 2;
  // Feed sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    WDTFG_IDLE    = 2'b00,
    WDTFG_ARMED   = 2'b01,
    WDTFG_PENDING = 2'b11
  } wdtfg_feed_t;
endpackage

/* File: logic/wdtfg_sync.sv */
// Two-flop level synchroniser into the CPU clock domain.
// Assumes the input may change at any time relative to i_clk.
`timescale 1ns/10ps
module wdtfg_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic stage1;

  // The first stage is read only by the second.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

/* File: logic/wdtfg_top.sv */
// Supervision timer with feed guard: prescaler, down counter, staged
// control and reload, feed sequencer and reset generator.
// Assumes an 8-bit register bus on i_clk, a slower watchdog oscillator
// sampled in from a pin, and i_rst driven only by power-on reset.
// Function
// - Reset the system on counter underflow when reset-on-underflow enabled.
// - Counter runs after power-on reset regardless of reset enable.
// - Run bit starts or stops the timer; reads set after reset.
// - 13-bit prescaler feeds 8-bit down counter through a selected tap.
// - Prescaler clocks from peripheral clock or oscillator per select bit.
// - Without reset enable, act as timer with interrupt; safety ignored.
// - Reset enabled, safety off: software picks the clock source.
// - Reset and safety on: oscillator forced, run forced, write-once.
// - Generated reset lasts at least one selected watchdog clock.
// - Reset pulse ends on clock; restart is the system's business.
// - Control and reload writes staged; control committed by a completed feed, reload by a feed or underflow.
// - In watchdog mode a wrong feed sequence or intervening write resets immediately.
// - In watchdog mode a control write must be followed by a feed.
// - Timer mode copies control every cycle; reload loads at a feed or an underflow.
// - Timeout is 2^(5+pre) times (reload+1) plus one watchdog clocks.
// - State is cleared only by power-on reset, not own resets.
// - Underflow sets time-out flag; a feed in watchdog mode or a zero write clears it.
// - Clock source change loads after a feed, with two-cycle switch.
`timescale 1ns/10ps
module wdtfg_top
  import wdtfg_pkg::*;
#(
  parameter int PCLK_DIV = 2
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_osc_clk,
  input  wire logic        i_reset_on_underflow_enable,
  input  wire logic        i_safety_lock_enable,
  input  wire logic        i_timeout_flag_at_reset,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  output logic             o_system_reset,
  output logic             o_timer_irq
);
  import wdtfg_pkg::*;

  // Width of the peripheral clock divider count.
  localparam int DIV_W = $clog2(PCLK_DIV);

  // Staged registers seen by software.
  logic [7:0] control_staged;
  logic [7:0] reload_value;
  logic       control_written_once;
  logic       reload_written_once;
  // Active state.
  logic [2:0] active_pre;
  logic       active_run;
  logic       active_clksel;
  logic       timeout_flag;
  logic       tof_loaded;
  logic [PRESCALER_BITS-1:0] prescaler;
  logic [COUNTER_BITS-1:0]   counter;
  logic       final_tick;
  wdtfg_feed_t feed_state;
  // Clock-source switch bookkeeping.
  logic       osc_sync;
  logic       osc_prev;
  logic [DIV_W-1:0] pclk_cnt;
  logic       src_cur;
  logic [1:0] switch_cnt;
  logic       fault_reset;
  logic       pulse_active;
  logic       pulse_seen_tick;

  // Decodes of the bus cycle.
  wire wr_control = i_wr && (i_addr == ADDR_CONTROL);
  wire wr_reload  = i_wr && (i_addr == ADDR_RELOAD);
  wire wr_feed1   = i_wr && (i_addr == ADDR_FEED_FIRST);
  wire wr_feed2   = i_wr && (i_addr == ADDR_FEED_SECOND);

  // Mode decode of the configuration byte.
  // Safety bit ignored unless reset-on-underflow is enabled
  wire wd_mode  = i_reset_on_underflow_enable;
  wire safe_on  = wd_mode && i_safety_lock_enable;

  // Feed completes on a correct second write after an armed first.
  wire feed_ok   = (feed_state == WDTFG_ARMED) && wr_feed2
                   && (i_wdata == FEED_SECOND_VALUE);
  wire feed_bad  = ((feed_state == WDTFG_ARMED) && i_wr && !feed_ok)
                   || (wr_feed1 && (i_wdata != FEED_FIRST_VALUE))
                   || (wr_feed2 && (feed_state != WDTFG_ARMED));
  wire pend_bad  = (feed_state == WDTFG_PENDING) && i_wr && !wr_feed1;

  // Write-once lock under safety mode.
  // Write-once guard
  wire ctrl_we   = wr_control && !(safe_on && control_written_once);
  wire rel_we    = wr_reload  && !(safe_on && reload_written_once);

  // Forced fields under safety mode.
  // Forced fields
  wire eff_clksel_req = safe_on ? 1'b1 : control_staged[BIT_CLKSEL];
  wire eff_run_req    = safe_on ? 1'b1 : control_staged[BIT_RUN];

  // Peripheral clock tick from a divider, and oscillator edge tick.
  wire pclk_tick = (pclk_cnt == DIV_W'(PCLK_DIV - 1));
  wire osc_tick  = osc_sync && !osc_prev;
  wire src_tick  = src_cur ? osc_tick : pclk_tick;
  wire new_tick  = active_clksel ? osc_tick : pclk_tick;
  wire switching = (src_cur != active_clksel);
  wire wd_tick   = src_tick && active_run && !switching;

  wire [PRESCALER_BITS-1:0] tap_mask =
    PRESCALER_BITS'(({{(PRESCALER_BITS-1){1'b0}}, 1'b1}
      << (TAP_BASE + int'(active_pre))) - 1);
  wire tap_hit   = wd_tick && ((prescaler & tap_mask) == tap_mask);
  wire underflow = wd_tick && final_tick;

  // Read mux of the staged control register.
  wire [7:0] control_view = {control_staged[BIT_PRE_LO +: 3], 2'b00,
                             control_staged[BIT_RUN] | safe_on,
                             timeout_flag,
                             control_staged[BIT_CLKSEL] | safe_on};
  wire [7:0] next_rdata = !i_rd ? 8'h00 :
                          (i_addr == ADDR_CONTROL) ? control_view :
                          (i_addr == ADDR_RELOAD)  ? reload_value : 8'h00;

  // Oscillator synchroniser from the pin.
  wdtfg_sync u_osc_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_osc_clk),
    .o_sync  (osc_sync)
  );

  // Edge history and peripheral divider.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_prev <= 1'b0;
      pclk_cnt <= '0;
    end else begin
      osc_prev <= osc_sync;
      pclk_cnt <= pclk_tick ? '0 : pclk_cnt + 1'b1;
    end
  end

  // Read data register.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // Staged registers.
  // Staged writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      control_staged       <= {RESET_PRE, 2'b00, RESET_RUN, 1'b0,
                               RESET_CLKSEL};
      reload_value         <= RESET_RELOAD;
      control_written_once <= 1'b0;
      reload_written_once  <= 1'b0;
    end else begin
      if (ctrl_we) begin
        control_staged       <= i_wdata;
        control_written_once <= 1'b1;
      end
      if (rel_we) begin
        reload_value        <= i_wdata;
        reload_written_once <= 1'b1;
      end
    end
  end

  // Feed sequencer.
  // Feed order
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      feed_state <= WDTFG_IDLE;
    end else begin
      case (feed_state)
        WDTFG_IDLE: begin
          if (wr_feed1 && i_wdata == FEED_FIRST_VALUE) begin
            feed_state <= WDTFG_ARMED;
          end else if (wr_control && wd_mode) begin
            feed_state <= WDTFG_PENDING;
          end
        end
        WDTFG_PENDING: begin
          if (wr_feed1 && i_wdata == FEED_FIRST_VALUE) begin
            feed_state <= WDTFG_ARMED;
          end else if (i_wr) begin
            feed_state <= WDTFG_IDLE;
          end
        end
        WDTFG_ARMED: begin
          if (i_wr) begin
            feed_state <= WDTFG_IDLE;
          end
        end
        default: begin
          feed_state <= WDTFG_IDLE;
        end
      endcase
    end
  end

  // Active control state.
  // Timer copy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      active_pre    <= RESET_PRE;
      active_run    <= RESET_RUN;
      active_clksel <= RESET_CLKSEL;
    end else if (feed_ok || !wd_mode) begin
      active_pre    <= control_staged[BIT_PRE_LO +: 3];
      active_run    <= eff_run_req;
      active_clksel <= eff_clksel_req;
    end else if (safe_on) begin
      active_run    <= 1'b1;
      active_clksel <= 1'b1;
    end
  end

  // Clock-source switch: two old ticks out, two new ticks in.
  // Counting pauses meanwhile so that no partial tick is ever counted.
  // Switch timing
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      src_cur    <= RESET_CLKSEL;
      switch_cnt <= 2'd0;
    end else if (!switching) begin
      switch_cnt <= 2'd0;
    end else if (switch_cnt < 2'(SWITCH_STAGES)) begin
      if (src_tick) begin
        switch_cnt <= switch_cnt + 2'd1;
      end
    end else if (new_tick) begin
      if (switch_cnt == 2'(2 * SWITCH_STAGES - 1)) begin
        src_cur    <= active_clksel;
        switch_cnt <= 2'd0;
      end else begin
        switch_cnt <= switch_cnt + 2'd1;
      end
    end
  end

  // Prescaler and down counter.
  // Prescaler restart
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prescaler  <= '0;
      counter    <= RESET_RELOAD;
      final_tick <= 1'b0;
    end else if (feed_ok) begin
      prescaler  <= '0;
      counter    <= reload_value;
      final_tick <= 1'b0;
    end else if (underflow) begin
      prescaler  <= '0;
      counter    <= reload_value;
      final_tick <= 1'b0;
    end else if (wd_tick) begin
      prescaler <= prescaler + 1'b1;
      if (tap_hit) begin
        prescaler <= '0;
        if (counter == '0) begin
          final_tick <= 1'b1;
        end else begin
          counter <= counter - 1'b1;
        end
      end
    end
  end

  // Time-out flag: set wins over a software or feed clear.
  // Flag set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tof_loaded   <= 1'b0;
      timeout_flag <= 1'b0;
    end else if (!tof_loaded) begin
      tof_loaded   <= 1'b1;
      timeout_flag <= i_timeout_flag_at_reset;
    end else if (underflow) begin
      timeout_flag <= 1'b1;
    end else if ((feed_ok && wd_mode)
                 || (ctrl_we && !i_wdata[BIT_TOF])) begin
      timeout_flag <= 1'b0;
    end
  end

  // Reset request from underflow or a broken feed.
  // Underflow reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_reset <= 1'b0;
    end else begin
      fault_reset <= (underflow && wd_mode)
                     || (wd_mode && (feed_bad || pend_bad));
    end
  end

  // Reset pulse held until a selected watchdog clock has passed.
  // Pulse length
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_active    <= 1'b0;
      pulse_seen_tick <= 1'b0;
    end else if (fault_reset) begin
      pulse_active    <= 1'b1;
      pulse_seen_tick <= 1'b0;
    end else if (pulse_active && src_tick) begin
      if (pulse_seen_tick) begin
        pulse_active <= 1'b0;
      end
      pulse_seen_tick <= 1'b1;
    end
  end

  // Outputs.
  // Timer interrupt
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_system_reset <= 1'b0;
      o_timer_irq    <= 1'b0;
    end else begin
      o_system_reset <= fault_reset || pulse_active;
      o_timer_irq    <= timeout_flag && !wd_mode;
    end
  end
endmodule

/* File: tb/wdtfg_chk.sv */
// Checker for the supervision timer with feed guard.
// Assumes it is bound to wdtfg_top and sees only its ports.
`timescale 1ns/10ps
module wdtfg_chk
  import wdtfg_pkg::*;
#(
  parameter int PCLK_DIV = 2
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_osc_clk,
  input wire logic       i_reset_on_underflow_enable,
  input wire logic       i_safety_lock_enable,
  input wire logic       i_timeout_flag_at_reset,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_system_reset,
  input wire logic       o_timer_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Decoded bus events used by several properties.
  wire logic wd_mode = i_reset_on_underflow_enable;
  wire logic arm_wr  = i_wr && i_addr == ADDR_FEED_FIRST
                       && i_wdata == FEED_FIRST_VALUE;
  wire logic ctl_wr  = i_wr && i_addr == ADDR_CONTROL;
  wire logic ctl_rd  = i_rd && i_addr == ADDR_CONTROL;

  chk_bad_first_feed: assert property (
    wd_mode && i_wr && i_addr == ADDR_FEED_FIRST && !arm_wr
    |-> ##[1:3] o_system_reset)
    else $error("wrong first feed value gave no reset");
  chk_write_while_armed: assert property (
    wd_mode && arm_wr ##1 (i_wr && i_addr != ADDR_FEED_SECOND)
    |-> ##[1:3] o_system_reset)
    else $error("write inside a feed gave no reset");
  chk_control_needs_feed: assert property (
    wd_mode && ctl_wr ##1 (i_wr && i_addr != ADDR_FEED_FIRST)
    |-> ##[1:3] o_system_reset)
    else $error("control write without feed gave no reset");
  chk_reset_hold_min: assert property (
    $rose(o_system_reset) |-> o_system_reset[*3])
    else $error("system reset pulse too short");
  chk_irq_timer_only: assert property (
    wd_mode && $past(wd_mode) |-> !o_timer_irq)
    else $error("timer interrupt raised in watchdog mode");
  chk_reserved_zero: assert property (
    ctl_rd |=> o_rdata[4:3] == 2'b00)
    else $error("reserved control bits read nonzero");
  chk_safety_forced: assert property (
    wd_mode && i_safety_lock_enable && ctl_rd
    |=> o_rdata[BIT_RUN] && o_rdata[BIT_CLKSEL])
    else $error("safety mode did not force run and clock");
  chk_rdata_quiet: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero without a read");
  chk_outputs_released: assert property (
    $fell(i_rst) |-> !o_system_reset && !o_timer_irq)
    else $error("outputs active right after power-on reset");

  // Main scenarios: a reset, a timer interrupt and a correct first feed followed by any write to the second feed address.
  cover property ($rose(o_system_reset));
  cover property ($rose(o_timer_irq));
  cover property (arm_wr ##1 (i_wr && i_addr == ADDR_FEED_SECOND));
endmodule

bind wdtfg_top wdtfg_chk #(.PCLK_DIV(PCLK_DIV)) u_chk (
  .i_clk                       (i_clk),
  .i_rst                       (i_rst),
  .i_osc_clk                   (i_osc_clk),
  .i_reset_on_underflow_enable (i_reset_on_underflow_enable),
  .i_safety_lock_enable        (i_safety_lock_enable),
  .i_timeout_flag_at_reset     (i_timeout_flag_at_reset),
  .i_wr                        (i_wr),
  .i_rd                        (i_rd),
  .i_addr                      (i_addr),
  .i_wdata                     (i_wdata),
  .o_rdata                     (o_rdata),
  .o_system_reset              (o_system_reset),
  .o_timer_irq                 (o_timer_irq)
);

/* File: tb/watchdog_timer_feed_guard_bench.sv */
// Self-checking bench for the supervision timer with feed guard.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps
module watchdog_timer_feed_guard_bench
  import wdtfg_pkg::*;
;
  logic       clk, rst, osc, wd_en, saf_en, flag0, wr, rd;
  logic [7:0] addr, wdata, rdata;
  logic       sys_rst, irq;
  int         n_mismatch, tests_run, cycles, n_rst, n, k;

  wdtfg_top #(.PCLK_DIV(2)) DUT (
    .i_clk                       (clk),
    .i_rst                       (rst),
    .i_osc_clk                   (osc),
    .i_reset_on_underflow_enable (wd_en),
    .i_safety_lock_enable        (saf_en),
    .i_timeout_flag_at_reset     (flag0),
    .i_wr                        (wr),
    .i_rd                        (rd),
    .i_addr                      (addr),
    .i_wdata                     (wdata),
    .o_rdata                     (rdata),
    .o_system_reset              (sys_rst),
    .o_timer_irq                 (irq)
  );

  // CPU clock of 50 ns and a free-running 1 us oscillator.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    forever #500 osc = ~osc;
  end

  // Hang guard and a count of generated system resets.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  always @(posedge sys_rst) n_rst++;

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wr_reg leaves the strobe up so writes can run back to back; idle and rd_reg drop it.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
  endtask
  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic feed;
    wr_reg(ADDR_FEED_FIRST, FEED_FIRST_VALUE);
    wr_reg(ADDR_FEED_SECOND, FEED_SECOND_VALUE);
    idle();
  endtask
  // Counts cycles up to a reset pulse, then waits for it to end.
  task automatic wait_rst(output int c);
    c = 0;
    while (sys_rst !== 1'b1 && c < 600) begin
      @(posedge clk);
      c++;
    end
    while (sys_rst !== 1'b0) @(posedge clk);
  endtask
  task automatic do_reset(input logic e, input logic s, input logic f);
    @(posedge clk);
    rst <= 1'b1;
    wd_en <= e;
    saf_en <= s;
    flag0 <= f;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    {rst, wd_en, saf_en, flag0, wr, rd} = 6'b110000;
    {addr, wdata} = 16'h0000;
    do_reset(1'b1, 1'b0, 1'b0);
    rd_reg(ADDR_CONTROL, 8'hE5);
    rd_reg(ADDR_RELOAD, 8'hFF);
    rd_reg(8'h00, 8'h00);
    $display("Test reset values done");
    // Each broken feed gives exactly one reset; state survives it.
    k = n_rst;
    wr_reg(ADDR_FEED_FIRST, 8'h00);
    idle();
    wait_rst(n);
    chk(8'(n_rst - k), 8'h01);
    wr_reg(ADDR_FEED_FIRST, FEED_FIRST_VALUE);
    wr_reg(ADDR_RELOAD, 8'hFF);
    idle();
    wait_rst(n);
    chk(8'(n_rst - k), 8'h02);
    wr_reg(ADDR_CONTROL, 8'hE5);
    wr_reg(ADDR_RELOAD, 8'hFF);
    idle();
    wait_rst(n);
    chk(8'(n_rst - k), 8'h03);
    wr_reg(ADDR_FEED_SECOND, FEED_SECOND_VALUE);
    idle();
    wait_rst(n);
    chk(8'(n_rst - k), 8'h04);
    wr_reg(ADDR_FEED_FIRST, FEED_FIRST_VALUE);
    rd_reg(ADDR_CONTROL, 8'hE5);
    wr_reg(ADDR_FEED_SECOND, FEED_SECOND_VALUE);
    idle();
    repeat (20) @(posedge clk);
    chk(8'(n_rst - k), 8'h04);
    $display("Test feed faults done");
    // Shortest period on the peripheral clock, then underflow.
    wr_reg(ADDR_RELOAD, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h04);
    feed();
    wait_rst(n);
    chk({7'h00, n >= 64 && n <= 160}, 8'h01);
    rd_reg(ADDR_CONTROL, 8'h06);
    feed();
    rd_reg(ADDR_CONTROL, 8'h04);
    wr_reg(ADDR_CONTROL, 8'h00);
    feed();
    k = n_rst;
    repeat (300) @(posedge clk);
    chk(8'(n_rst - k), 8'h00);
    $display("Test time-out done");
    // Timer mode raises the interrupt and ignores bad feeds.
    do_reset(1'b0, 1'b0, 1'b1);
    #1 chk({7'h00, irq}, 8'h01);
    wr_reg(ADDR_RELOAD, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h04);
    feed();
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    k = n_rst;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, irq}, 8'h01);
    wr_reg(ADDR_FEED_FIRST, 8'h00);
    idle();
    repeat (60) @(posedge clk);
    chk(8'(n_rst - k), 8'h00);
    $display("Test timer mode done");
    // Safety mode forces run and clock and takes one control write.
    do_reset(1'b1, 1'b1, 1'b0);
    wr_reg(ADDR_CONTROL, 8'h00);
    feed();
    rd_reg(ADDR_CONTROL, 8'h05);
    wr_reg(ADDR_CONTROL, 8'hE0);
    feed();
    rd_reg(ADDR_CONTROL, 8'h05);
    $display("Test safety mode done");
    give_verdict();
  end
endmodule
